// ### logic/bidso_pkg.sv
`default_nettype none
package bidso_pkg;

  // output format selection
  typedef enum logic [1:0] {
    FMT_NONE = 2'h0,
    FMT_W26 = 2'h1,
    FMT_W33 = 2'h2,
    FMT_CD = 2'h3
  } bidso_fmt_t;

  localparam int ID_W = 17;
  localparam int DIGITS = 5;
  localparam int BCD_W = DIGITS * 4;

  // one identifier to send, with the format chosen for it
  typedef struct packed {
    bidso_fmt_t fmt;
    logic strobeEn;
    logic [ID_W-1:0] facility;
    logic [ID_W-1:0] userId;
  } bidso_req_t;

  // frame layout
  localparam int FRAME_W = 60;
  localparam int LEFT_W = 6;
  localparam logic [LEFT_W-1:0] W26_BITS = 6'h1A;
  localparam logic [LEFT_W-1:0] W33_BITS = 6'h21;
  localparam logic [LEFT_W-1:0] CD_BITS = 6'h3C;
  localparam int CD_CHARS = 12;
  localparam int CHAR_BITS = 5;
  localparam int W26_FAC_W = 8;
  localparam int W_FIELD_W = 16;
  localparam int W26_LOW_PAR_W = 12;
  localparam logic [3:0] START_CHAR = 4'hB;
  localparam logic [3:0] END_CHAR = 4'hF;

  // timing, in the unit printed
  localparam longint LINK_CLK_PS = 12000;
  localparam longint PS_PER_NS = 1000;
  localparam longint BIT_PULSE_WIDTH_NS = 100000;
  localparam longint BIT_PERIOD_NS = 1000000;
  localparam longint STROBE_LEAD_PP_NS = 10000000;
  localparam longint STROBE_LEAD_CD_NS = 12000000;
  localparam longint CD_CLK_PERIOD_NS = 320000;
  localparam longint CD_SETUP_NS = 100000;
  localparam longint CLOCK_LOW_NS = 100000;
  localparam int CNT_W = 24;

  // time to whole link clock cycles, never below one
  function automatic int toCyc(longint ns, longint ps);
    longint c;
    c = ns * PS_PER_NS / ps;
    return (c < 1) ? 1 : int'(c);
  endfunction

endpackage
`default_nettype wire

// ### logic/bidso_sync.sv
`timescale 1ns/1ns
`default_nettype none
module bidso_sync (
  input wire logic clk, // destination clock
  input wire logic rstn, // async reset, active low
  input wire logic d, // level from the other domain
  output logic q // synchronised level
);
  logic meta_q;
  logic sync_q;

  // two stages, first one read only by the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule
`default_nettype wire

// ### logic/bidso_bcd.sv
`timescale 1ns/1ns
`default_nettype none
module bidso_bcd #(
  parameter int BIN_W = 17,
  parameter int DIG = 5
) (
  input wire logic clk, // conversion clock
  input wire logic rstn, // async reset, active low
  input wire logic start, // one-cycle start pulse
  input wire logic [BIN_W-1:0] bin, // binary value, held during conversion
  output logic [DIG*4-1:0] bcd, // packed digits, most significant on top
  output logic done // level, high once digits are valid
);
  localparam int SH_W = DIG * 4 + BIN_W;
  localparam int N_W = $clog2(BIN_W + 1);

  logic [SH_W-1:0] sh_q;
  logic [N_W-1:0] n_q;
  logic done_q;

  // add three to every digit of five or more
  function automatic logic [DIG*4-1:0] adj(logic [DIG*4-1:0] v);
    logic [DIG*4-1:0] r;
    r = v;
    for (int i = 0; i < DIG; i++) begin
      if (r[i*4 +: 4] >= 4'h5) r[i*4 +: 4] = r[i*4 +: 4] + 4'h3;
    end
    return r;
  endfunction

  // shift-and-add, one input bit per clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_q <= '0;
      n_q <= '0;
      done_q <= 1'b0;
    end else if (start) begin
      sh_q <= {{(DIG*4){1'b0}}, bin};
      n_q <= N_W'(BIN_W);
      done_q <= 1'b0;
    end else if (n_q != '0) begin
      sh_q <= {adj(sh_q[SH_W-1 -: DIG*4]), sh_q[BIN_W-1:0]} << 1;
      n_q <= n_q - 1'b1;
      done_q <= (n_q == N_W'(1));
    end
  end

  assign bcd = sh_q[SH_W-1 -: DIG*4];
  assign done = done_q;
endmodule
`default_nettype wire

// ### logic/bidso_serial_out.sv
// Function
// - 26-bit frame bit 1 is even parity over bits 2 to 13.
// - 26-bit frame bits 2-9 carry low 8 facility bits, MSB first.
// - 26-bit frame bits 10-25 carry the 16-bit user ID, MSB first.
// - 26-bit frame bit 26 is odd parity over bits 14 to 25.
// - 33-bit frame bits 1-16 carry the low 16 facility bits, MSB first.
// - 33-bit frame bits 17-32 carry the 16-bit user ID, MSB first.
// - 33-bit frame bit 33 is odd parity over bits 1 to 32.
// - all lines active low: pulled low to assert, released otherwise.
// - pulse-pair gap between pulses 800 to 1000 us, nominal 900.
// - pulse-pair bit period 900 to 1100 us, nominal 1000.
// - pulse-pair strobe leads first bit and trails last by 10 ms.
// - strobe is optional; disabled means it stays released.
// - clock-and-data: data presented, then falling clock edge samples it.
// - clock-and-data clock period 290 to 350 us, nominal 320.
// - clock-and-data data stable about 100 us before falling edge.
// - clock-and-data clock low phase 50 to 150 us, nominal 100.
// - clock-and-data strobe leads first bit and trails last by 12 ms.
// - character is four BCD bits LSB first plus odd parity.
// - message is start B, 5 facility, 5 user digits, end F.
// - facility code as five zero-padded BCD digits, MSD first.
// - user ID as five zero-padded BCD digits, MSD first.
// - format setting selects none or a variant; none sends nothing.
`timescale 1ns/1ns
`default_nettype none
module bidso_serial_out
  import bidso_pkg::*;
#(
  parameter int PULSE_CYC = toCyc(BIT_PULSE_WIDTH_NS, LINK_CLK_PS),
  parameter int GAP_CYC =
    toCyc(BIT_PERIOD_NS - BIT_PULSE_WIDTH_NS, LINK_CLK_PS),
  parameter int PP_LEAD_CYC = toCyc(STROBE_LEAD_PP_NS, LINK_CLK_PS),
  parameter int CD_LEAD_CYC = toCyc(STROBE_LEAD_CD_NS, LINK_CLK_PS),
  parameter int SETUP_CYC = toCyc(CD_SETUP_NS, LINK_CLK_PS),
  parameter int CLKLO_CYC = toCyc(CLOCK_LOW_NS, LINK_CLK_PS),
  parameter int CLKHI_CYC = toCyc(
    CD_CLK_PERIOD_NS - CD_SETUP_NS - CLOCK_LOW_NS, LINK_CLK_PS)
) (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic rstn, // async reset, active low
  input wire logic linkClk, // line timing clock
  input wire logic idValid, // offer of an identifier
  input wire bidso_fmt_t fmt, // output format for this identifier
  input wire logic strobeEn, // card load strobe enable
  input wire logic [ID_W-1:0] facility, // facility code
  input wire logic [ID_W-1:0] userId, // user id
  output logic idReady, // high while a new identifier is taken
  output logic zeroPulseLineAltO, // zero line or data, level
  output logic zeroPulseLineAltOe, // drive enable, high pulls low
  output logic onePulseLineO, // one line or clock, level
  output logic onePulseLineOe, // drive enable, high pulls low
  output logic cardLoadStrobeO, // card load strobe, level
  output logic cardLoadStrobeOe // drive enable, high pulls low
);

  // link side states
  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_CONV = 10'h002,
    S_LEAD = 10'h004,
    S_PULSE = 10'h008,
    S_GAP = 10'h010,
    S_SETUP = 10'h020,
    S_CLKLO = 10'h040,
    S_CLKHI = 10'h080,
    S_TRAIL = 10'h100,
    S_SPARE = 10'h200
  } bidso_state_t;

  // system side
  bidso_req_t held_q;
  logic reqTgl_q;
  logic ackSeen_q;
  logic idReady_q;
  logic ackSync;

  // link side
  bidso_state_t state_q;
  bidso_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [FRAME_W-1:0] frame_q;
  logic [FRAME_W-1:0] frame_d;
  logic [LEFT_W-1:0] left_q;
  logic [LEFT_W-1:0] left_d;
  logic reqSync;
  logic reqSeen_q;
  logic ackTgl_q;
  logic startEv;
  logic bcdStart;
  logic facDone;
  logic [BCD_W-1:0] facBcd;
  logic [BCD_W-1:0] usrBcd;
  logic isPp;
  logic tick;
  logic curBit;
  logic [CNT_W-1:0] leadCnt;
  logic zeroAs;
  logic oneAs;
  logic strbAs;
  logic zeroO_q;
  logic zeroOe_q;
  logic oneO_q;
  logic oneOe_q;
  logic strbO_q;
  logic strbOe_q;

  // one character: BCD bits least significant first, then odd parity
  function automatic logic [CHAR_BITS-1:0] charBits(logic [3:0] d);
    return {d[0], d[1], d[2], d[3], ~^d};
  endfunction

  // whole frame, first bit sent at the top
  function automatic logic [FRAME_W-1:0] buildFrame(
    bidso_fmt_t f,
    logic [ID_W-1:0] fac,
    logic [ID_W-1:0] usr,
    logic [BCD_W-1:0] fb,
    logic [BCD_W-1:0] ub
  );
    logic [FRAME_W-1:0] r;
    logic [W26_FAC_W-1:0] f8;
    logic [W_FIELD_W-1:0] f16;
    logic [W_FIELD_W-1:0] u16;
    logic [3:0] dg;
    r = '0;
    f8 = fac[W26_FAC_W-1:0];
    f16 = fac[W_FIELD_W-1:0];
    u16 = usr[W_FIELD_W-1:0];
    dg = 4'h0;
    case (f)
      FMT_W26: begin
        r[FRAME_W-1 -: 26] = {
          ^{f8, u16[W_FIELD_W-1 -: 4]},
          f8,
          u16,
          ~^u16[W26_LOW_PAR_W-1:0]
        };
      end
      FMT_W33: begin
        r[FRAME_W-1 -: 33] = {
          f16,
          u16,
          ~^{f16, u16}
        };
      end
      FMT_CD: begin
        for (int i = 0; i < CD_CHARS; i++) begin
          if (i == 0) dg = START_CHAR;
          else if (i <= DIGITS) dg = fb[(DIGITS - i) * 4 +: 4];
          else if (i <= 2 * DIGITS) dg = ub[(2 * DIGITS - i) * 4 +: 4];
          else dg = END_CHAR;
          r[FRAME_W - 1 - CHAR_BITS * i -: CHAR_BITS] = charBits(dg);
        end
      end
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  // acknowledge back from the link side
  bidso_sync u_ackSync (
    .clk(mclk),
    .rstn(rstn),
    .d(ackTgl_q),
    .q(ackSync)
  );

  // take an identifier, hold it until the link side finishes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      held_q <= '0;
      reqTgl_q <= 1'b0;
      ackSeen_q <= 1'b0;
      idReady_q <= 1'b1;
    end else if (idValid && idReady_q && fmt != FMT_NONE) begin
      held_q <= '{fmt, strobeEn, facility, userId};
      reqTgl_q <= !reqTgl_q;
      idReady_q <= 1'b0;
    end else if (!idReady_q && ackSync != ackSeen_q) begin
      ackSeen_q <= ackSync;
      idReady_q <= 1'b1;
    end
  end

  assign idReady = idReady_q;

  // request toggle into the link domain
  bidso_sync u_reqSync (
    .clk(linkClk),
    .rstn(rstn),
    .d(reqTgl_q),
    .q(reqSync)
  );

  // decimal digits for the clock-and-data format
  bidso_bcd #(
    .BIN_W(ID_W),
    .DIG(DIGITS)
  ) u_facBcd (
    .clk(linkClk),
    .rstn(rstn),
    .start(bcdStart),
    .bin(held_q.facility),
    .bcd(facBcd),
    .done(facDone)
  );

  bidso_bcd #(
    .BIN_W(ID_W),
    .DIG(DIGITS)
  ) u_usrBcd (
    .clk(linkClk),
    .rstn(rstn),
    .start(bcdStart),
    .bin(held_q.userId),
    .bcd(usrBcd),
    .done()
  );

  // decode of the current step
  assign startEv = (reqSync != reqSeen_q);
  assign bcdStart = (state_q == S_IDLE) && startEv;
  assign isPp = (held_q.fmt != FMT_CD);
  assign tick = (cnt_q == '0);
  assign curBit = frame_q[FRAME_W-1];
  assign leadCnt = isPp ? CNT_W'(PP_LEAD_CYC - 1)
                        : CNT_W'(CD_LEAD_CYC - 1);

  // sequencer: lead, bits, trail
  always_comb begin
    state_d = state_q;
    cnt_d = tick ? cnt_q : cnt_q - 1'b1;
    frame_d = frame_q;
    left_d = left_q;
    case (state_q)
      S_IDLE: begin
        if (startEv) state_d = S_CONV;
      end
      S_CONV: begin
        if (facDone) begin
          frame_d = buildFrame(held_q.fmt, held_q.facility,
            held_q.userId, facBcd, usrBcd);
          left_d = (held_q.fmt == FMT_W26) ? W26_BITS :
                   (held_q.fmt == FMT_W33) ? W33_BITS : CD_BITS;
          cnt_d = leadCnt;
          state_d = S_LEAD;
        end
      end
      S_LEAD: begin
        if (tick && isPp) begin
          cnt_d = CNT_W'(PULSE_CYC - 1);
          state_d = S_PULSE;
        end else if (tick) begin
          cnt_d = CNT_W'(SETUP_CYC - 1);
          state_d = S_SETUP;
        end
      end
      S_PULSE: begin
        if (tick) begin
          left_d = left_q - 1'b1;
          if (left_q == LEFT_W'(1)) begin
            cnt_d = leadCnt;
            state_d = S_TRAIL;
          end else begin
            cnt_d = CNT_W'(GAP_CYC - 1);
            state_d = S_GAP;
          end
        end
      end
      S_GAP: begin
        if (tick) begin
          frame_d = frame_q << 1;
          cnt_d = CNT_W'(PULSE_CYC - 1);
          state_d = S_PULSE;
        end
      end
      S_SETUP: begin
        if (tick) begin
          cnt_d = CNT_W'(CLKLO_CYC - 1);
          state_d = S_CLKLO;
        end
      end
      S_CLKLO: begin
        if (tick) begin
          left_d = left_q - 1'b1;
          if (left_q == LEFT_W'(1)) begin
            cnt_d = leadCnt;
            state_d = S_TRAIL;
          end else begin
            cnt_d = CNT_W'(CLKHI_CYC - 1);
            state_d = S_CLKHI;
          end
        end
      end
      S_CLKHI: begin
        if (tick) begin
          frame_d = frame_q << 1;
          cnt_d = CNT_W'(SETUP_CYC - 1);
          state_d = S_SETUP;
        end
      end
      S_TRAIL: begin
        if (tick) state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      frame_q <= '0;
      left_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      frame_q <= frame_d;
      left_q <= left_d;
    end
  end

  // handshake: note request, acknowledge after the trail
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      reqSeen_q <= 1'b0;
      ackTgl_q <= 1'b0;
    end else begin
      if (bcdStart) reqSeen_q <= reqSync;
      if (state_q == S_TRAIL && tick) ackTgl_q <= !ackTgl_q;
    end
  end

  // line assertions per state
  always_comb begin
    zeroAs = ((state_q == S_PULSE) && !curBit)
          || ((state_q == S_SETUP || state_q == S_CLKLO
              || state_q == S_CLKHI) && curBit);
    oneAs = ((state_q == S_PULSE) && curBit)
         || (state_q == S_CLKLO);
    strbAs = held_q.strobeEn
          && (state_q != S_IDLE) && (state_q != S_CONV);
  end

  // open-drain pins: enable pulls low, level mirrors the line
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      zeroO_q <= 1'b1;
      zeroOe_q <= 1'b0;
      oneO_q <= 1'b1;
      oneOe_q <= 1'b0;
      strbO_q <= 1'b1;
      strbOe_q <= 1'b0;
    end else begin
      zeroO_q <= !zeroAs;
      zeroOe_q <= zeroAs;
      oneO_q <= !oneAs;
      oneOe_q <= oneAs;
      strbO_q <= !strbAs;
      strbOe_q <= strbAs;
    end
  end

  assign zeroPulseLineAltO = zeroO_q;
  assign zeroPulseLineAltOe = zeroOe_q;
  assign onePulseLineO = oneO_q;
  assign onePulseLineOe = oneOe_q;
  assign cardLoadStrobeO = strbO_q;
  assign cardLoadStrobeOe = strbOe_q;

endmodule
`default_nettype wire

// ### sim/bidso_serial_out_properties.sv
`timescale 1ns/1ns
`default_nettype none
module bidso_serial_out_properties
  import bidso_pkg::*;
#(
  parameter int PULSE_CYC = 4,
  parameter int SETUP_CYC = 4,
  parameter int CLKLO_CYC = 4
) (
  input wire logic mclk, // system clock
  input wire logic rstn, // reset, active low
  input wire logic linkClk, // line clock
  input wire logic idValid, // offer
  input wire bidso_fmt_t fmt, // format
  input wire logic strobeEn, // strobe enable
  input wire logic idReady, // ready
  input wire logic zeroPulseLineAltO, // zero or data level
  input wire logic zeroPulseLineAltOe, // zero or data drive
  input wire logic onePulseLineO, // one or clock level
  input wire logic onePulseLineOe, // one or clock drive
  input wire logic cardLoadStrobeO, // strobe level
  input wire logic cardLoadStrobeOe // strobe drive
);
  logic ppMode_q;
  logic strbOff_q;
  logic zPrev_q;
  int oneRun_q;
  int zeroRun_q;
  int dataAge_q;

  // mode of the identifier taken last
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ppMode_q <= 1'b0;
      strbOff_q <= 1'b0;
    end else if (idValid && idReady && fmt != FMT_NONE) begin
      ppMode_q <= fmt != FMT_CD;
      strbOff_q <= !strobeEn;
    end
  end

  // run lengths of asserted lines, age of the data level
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      oneRun_q <= 0;
      zeroRun_q <= 0;
      dataAge_q <= 0;
      zPrev_q <= 1'b0;
    end else begin
      oneRun_q <= onePulseLineOe ? oneRun_q + 1 : 0;
      zeroRun_q <= zeroPulseLineAltOe ? zeroRun_q + 1 : 0;
      dataAge_q <= (zeroPulseLineAltOe != zPrev_q) ? 0 : dataAge_q + 1;
      zPrev_q <= zeroPulseLineAltOe;
    end
  end

  line_level_a: assert property (@(posedge linkClk) disable iff (!rstn)
    zeroPulseLineAltO == !zeroPulseLineAltOe &&
    onePulseLineO == !onePulseLineOe && cardLoadStrobeO == !cardLoadStrobeOe)
    else $error("line level is not the inverse of its drive");
  pp_exclusive_a: assert property (@(posedge linkClk) disable iff (!rstn)
    ppMode_q |-> !(zeroPulseLineAltOe && onePulseLineOe))
    else $error("both pulse lines asserted");
  one_width_a: assert property (@(posedge linkClk) disable iff (!rstn)
    $fell(onePulseLineOe) |-> oneRun_q == (ppMode_q ? PULSE_CYC : CLKLO_CYC))
    else $error("one line or clock low phase has wrong length");
  zero_width_a: assert property (@(posedge linkClk) disable iff (!rstn)
    ppMode_q && $fell(zeroPulseLineAltOe) |-> zeroRun_q == PULSE_CYC)
    else $error("zero line pulse has wrong length");
  strobe_off_a: assert property (@(posedge linkClk) disable iff (!rstn)
    strbOff_q |-> !cardLoadStrobeOe)
    else $error("strobe asserted while disabled");
  data_hold_a: assert property (@(posedge linkClk) disable iff (!rstn)
    !ppMode_q && onePulseLineOe |-> $stable(zeroPulseLineAltOe))
    else $error("data changed during clock low");
  data_setup_a: assert property (@(posedge linkClk) disable iff (!rstn)
    !ppMode_q && $rose(onePulseLineOe) |-> dataAge_q >= SETUP_CYC - 1)
    else $error("data set up too late before clock fall");
  busy_strobe_a: assert property (@(posedge mclk) disable iff (!rstn)
    cardLoadStrobeOe |-> !idReady)
    else $error("ready while strobe asserted");
  take_drop_a: assert property (@(posedge mclk) disable iff (!rstn)
    idValid && idReady && fmt != FMT_NONE |=> !idReady [*3])
    else $error("ready did not drop after a take");
  none_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
    idValid && idReady && fmt == FMT_NONE |=> idReady)
    else $error("ready dropped for format none");

  // main scenarios seen
  cover property (@(posedge linkClk) ppMode_q && $fell(onePulseLineOe));
  cover property (@(posedge linkClk) !ppMode_q && $rose(onePulseLineOe));
  cover property (@(posedge linkClk) $rose(cardLoadStrobeOe));
endmodule
`default_nettype wire

// ### sim/bidso_term_model.sv
`timescale 1ns/1ns
`default_nettype none
module bidso_term_model (
  input wire logic linkClk, // line clock
  input wire logic clr, // forget last frame
  input wire logic cdMode, // clock-and-data terminal
  input wire logic zeroLn, // zero or data wire
  input wire logic oneLn, // one or clock wire
  input wire logic strbLn, // strobe wire
  output logic [63:0] bits, // bits, first sent on top
  output int nBits, // bits received
  output int lead, // strobe low to first bit
  output int per, // cycles between the last two bits
  output int trail // strobe low after the last bit
);
  int since;
  logic zP = 1'b1;
  logic oP = 1'b1;
  logic got;
  logic val;
  // a bit lands on a falling wire, the clock fall in clock-and-data
  assign got = cdMode ? (oP && !oneLn) :
    ((zP && !zeroLn) || (oP && !oneLn));
  assign val = cdMode ? !zeroLn : !oneLn;
  // collect bits and time the strobe lead
  always @(posedge linkClk) begin
    zP <= zeroLn;
    oP <= oneLn;
    if (clr) begin
      bits <= '0;
      nBits <= 0;
      lead <= 0;
      since <= 0;
      per <= 0;
      trail <= 0;
    end else begin
      if (!strbLn && nBits == 0)
        lead <= lead + 1;
      since <= got ? 1 : since + 1;
      if (got)
        trail <= 0;
      else if (!strbLn && nBits != 0)
        trail <= trail + 1;
      if (got) begin
        per <= since;
        bits <= {bits[62:0], val};
        nBits <= nBits + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import bidso_pkg::*;
;
  localparam int PP_LEAD = 50;
  localparam int CD_LEAD = 60;
  localparam int SETUP = 4;
  logic mclk = 1'b0;
  logic linkClk = 1'b0;
  logic rstn = 1'b0;
  logic idValid = 1'b0;
  logic strobeEn = 1'b0;
  logic clr = 1'b1;
  logic cdMode = 1'b0;
  bidso_fmt_t fmt = FMT_NONE;
  logic [ID_W-1:0] facility = '0;
  logic [ID_W-1:0] userId = '0;
  logic idReady, zO, zOe, oO, oOe, sO, sOe, zW, oW, sW;
  logic [63:0] bits;
  int nBits;
  int lead;
  int per;
  int trail;
  int errors = 0;
  int compares = 0;

  // system clock, and a line clock whose edges meet it only every 30 ns
  always #5 mclk = ~mclk;
  always #6 linkClk = ~linkClk;
  // open-drain wires with pull-up
  assign zW = zOe ? 1'b0 : 1'b1;
  assign oW = oOe ? 1'b0 : 1'b1;
  assign sW = sOe ? 1'b0 : 1'b1;

  bidso_serial_out #(.PULSE_CYC(4), .GAP_CYC(36), .PP_LEAD_CYC(PP_LEAD),
    .CD_LEAD_CYC(CD_LEAD), .SETUP_CYC(SETUP), .CLKLO_CYC(4),
    .CLKHI_CYC(5)) u_dut (.mclk(mclk), .rstn(rstn), .linkClk(linkClk),
    .idValid(idValid), .fmt(fmt), .strobeEn(strobeEn),
    .facility(facility), .userId(userId), .idReady(idReady),
    .zeroPulseLineAltO(zO), .zeroPulseLineAltOe(zOe),
    .onePulseLineO(oO), .onePulseLineOe(oOe),
    .cardLoadStrobeO(sO), .cardLoadStrobeOe(sOe));
  bidso_term_model u_term (.linkClk(linkClk), .clr(clr), .cdMode(cdMode),
    .zeroLn(zW), .oneLn(oW), .strbLn(sW), .bits(bits), .nBits(nBits),
    .lead(lead), .per(per), .trail(trail));

  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic check_rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[ERR] %0t got %0h exp %0h..%0h", $time, got, lo, hi);
    end
  endtask

  // offer one identifier after clearing the terminal
  task automatic issue(input bidso_fmt_t f, input logic s,
    input logic [ID_W-1:0] fa, input logic [ID_W-1:0] us);
    clr <= 1'b1;
    cdMode <= f == FMT_CD;
    repeat (3) @(posedge mclk);
    clr <= 1'b0;
    fmt <= f;
    strobeEn <= s;
    facility <= fa;
    userId <= us;
    idValid <= 1'b1;
    @(posedge mclk);
    idValid <= 1'b0;
  endtask

  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    repeat (2) @(negedge mclk);
    while (idReady !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
    end
    if (n >= lim) begin
      errors++;
      give_verdict();
    end
  endtask

  task automatic sc_none();
    check({61'h0, sW, zW, oW}, 64'h7);
    issue(FMT_NONE, 1'b1, 17'h00001, 17'h00002);
    repeat (300) @(negedge mclk);
    check({63'h0, idReady}, 64'h1);
    check(64'(nBits), 64'h0);
    check(64'(lead), 64'h0);
  endtask

  task automatic sc_w26();
    logic [63:0] e;
    e = '0;
    e[24:1] = {8'hA5, 16'hBEEF};
    e[25] = ^e[24:13];
    e[0] = ~^e[12:1];
    issue(FMT_W26, 1'b1, 17'h1A3A5, 17'h1BEEF);
    repeat (100) @(posedge mclk);
    idValid <= 1'b1;
    fmt <= FMT_W33;
    @(posedge mclk);
    idValid <= 1'b0;
    wait_ready(5000);
    check(bits, e);
    check(64'(nBits), 64'h1A);
    check_rng(lead, PP_LEAD - 1, PP_LEAD + 2);
    check(64'(per), 64'h28);
    check_rng(trail, PP_LEAD + 2, PP_LEAD + 5);
  endtask

  task automatic sc_w33();
    logic [63:0] e;
    e = {31'h0, 16'h8001, 16'h7FFE, ~^{16'h8001, 16'h7FFE}};
    issue(FMT_W33, 1'b0, 17'h08001, 17'h07FFE);
    wait_ready(5000);
    check(bits, e);
    check(64'(nBits), 64'h21);
    check(64'(lead), 64'h0);
    check(64'(trail), 64'h0);
    check(64'(per), 64'h28);
  endtask

  task automatic sc_cd(input logic [ID_W-1:0] fa, input logic [ID_W-1:0] us);
    logic [63:0] e;
    logic [3:0] ch [12];
    ch[0] = START_CHAR;
    ch[11] = END_CHAR;
    for (int k = 0; k < 5; k++) begin
      ch[1 + k] = 4'((fa / 10 ** (4 - k)) % 10);
      ch[6 + k] = 4'((us / 10 ** (4 - k)) % 10);
    end
    e = '0;
    for (int i = 0; i < 12; i++) begin
      for (int j = 0; j < 5; j++) begin
        e = {e[62:0], (j < 4) ? ch[i][j] : ~^ch[i]};
      end
    end
    issue(FMT_CD, 1'b1, fa, us);
    wait_ready(5000);
    check(bits, e);
    check(64'(nBits), 64'h3C);
    check_rng(lead, CD_LEAD - 1, CD_LEAD + SETUP + 2);
    check(64'(per), 64'hD);
    check_rng(trail, CD_LEAD + 2, CD_LEAD + 5);
  endtask

  // reset, then the scenarios
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    sc_none();
    sc_w26();
    sc_w33();
    sc_cd(17'h00233, 17'h00DDF);
    sc_cd(17'h1869F, 17'h00000);
    give_verdict();
  end
endmodule

bind bidso_serial_out bidso_serial_out_properties #(.PULSE_CYC(PULSE_CYC),
  .SETUP_CYC(SETUP_CYC), .CLKLO_CYC(CLKLO_CYC)) u_props (.mclk(mclk),
  .rstn(rstn), .linkClk(linkClk), .idValid(idValid), .fmt(fmt),
  .strobeEn(strobeEn), .idReady(idReady),
  .zeroPulseLineAltO(zeroPulseLineAltO),
  .zeroPulseLineAltOe(zeroPulseLineAltOe),
  .onePulseLineO(onePulseLineO), .onePulseLineOe(onePulseLineOe),
  .cardLoadStrobeO(cardLoadStrobeO), .cardLoadStrobeOe(cardLoadStrobeOe));
`default_nettype wire
